// [hdl/valve_actuation_pkg.sv]
// Shared constants and carrier types for the actuation priority block
package valve_actuation_pkg;

  // Component and redundancy counts
  localparam int NS_INPUTS = 14;
  localparam int NUM_DIVISIONS = 2;
  localparam int NUM_MODULES = 2;
  localparam int DEFAULT_VALVES = 10;
  localparam int SYNC_STAGES = 2;

  // Reset values: everything comes up de-energized, the protective state
  localparam logic ENERGIZE_RESET = 1'b0;
  localparam logic SEAL_RESET = 1'b0;
  localparam logic [NS_INPUTS-1:0] VEC_RESET = 14'h0000;

  // One bit per component: valves low, breakers high
  typedef logic [NS_INPUTS-1:0] comp_vec_t;

  // Everything one division presents to the block
  typedef struct packed {
    comp_vec_t safety_demand;
    comp_vec_t ns_command;
    logic ns_enable;
    comp_vec_t position_reached;
    logic [NUM_MODULES-1:0] module_in_service;
  } division_in_t;

  localparam division_in_t DIV_IN_RESET = '{
    safety_demand: 14'h0000,
    ns_command: 14'h0000,
    ns_enable: 1'b0,
    position_reached: 14'h0000,
    module_in_service: 2'h0
  };

  // Per-module results handed back to the division combiner
  typedef struct packed {
    comp_vec_t energize;
    comp_vec_t sealed;
    comp_vec_t ns_blocked;
  } module_out_t;

endpackage : valve_actuation_pkg

// [hdl/priority_arbitration_logic.sv]
// One redundant actuation output module: seal-in and safety-over-nonsafety priority
`timescale 1ns/100ps
`default_nettype none

module priority_arbitration_logic (
  input wire logic clk, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic in_service, // Module fitted and running
  input wire valve_actuation_pkg::comp_vec_t safety_demand, // Protective demand per component
  input wire valve_actuation_pkg::comp_vec_t ns_command, // Nonsafety energize request per component
  input wire logic ns_enable, // Division nonsafety enable switch
  input wire valve_actuation_pkg::comp_vec_t position_reached, // Protective position confirmed
  output var valve_actuation_pkg::module_out_t result // Drive, seal and refusal state
);

  // A removed module behaves as held in reset, so its output drops
  logic live;
  valve_actuation_pkg::comp_vec_t energize_r;
  valve_actuation_pkg::comp_vec_t sealed_r;
  valve_actuation_pkg::comp_vec_t blocked_r;

  // Protection wins whenever a demand is present or a seal is holding
  function automatic logic protect_active(input logic demand, input logic seal);
    return demand | seal;
  endfunction : protect_active

  assign live = resetn & in_service;

  genvar i;
  generate
    for (i = 0; i < valve_actuation_pkg::NS_INPUTS; i++) begin : g_comp
      // Seal-in: set by demand, held until the feedback confirms the position
      always_ff @(posedge clk) begin
        if (!live) begin
          sealed_r[i] <= valve_actuation_pkg::SEAL_RESET;
        end else begin
          sealed_r[i] <= safety_demand[i] | (sealed_r[i] & ~position_reached[i]);
        end
      end

      // Drive state: cleared by protection, else set by enabled nonsafety
      always_ff @(posedge clk) begin
        if (!live) begin
          energize_r[i] <= valve_actuation_pkg::ENERGIZE_RESET;
        end else if (protect_active(safety_demand[i], sealed_r[i])) begin
          energize_r[i] <= 1'b0;
        end else if (ns_enable) begin
          energize_r[i] <= ns_command[i];
        end
      end

      // Flags a nonsafety energize request that protection is refusing
      always_ff @(posedge clk) begin
        if (!live) begin
          blocked_r[i] <= 1'b0;
        end else begin
          blocked_r[i] <= ns_enable & ns_command[i] & protect_active(safety_demand[i], sealed_r[i]);
        end
      end
    end
  endgenerate

  assign result.energize = energize_r;
  assign result.sealed = sealed_r;
  assign result.ns_blocked = blocked_r;

endmodule : priority_arbitration_logic

`default_nettype wire

// [hdl/valve_breaker_actuation_priority.sv]
// Two-division actuation priority block driving valve solenoids and trip-breaker coils
//
// Contract
// - Energize a valve solenoid to open the valve, de-energize it to close.
// - A division's solenoid drops only when both redundant module outputs are de-energized.
// - Each division drives its own solenoid; one division alone can de-energize it.
// - One nonsafety enable switch per division gates nonsafety control of all components.
// - Nonsafety commands arrive as fourteen separate hardwired inputs.
// - Priority logic is duplicated so one module can be removed for maintenance.
// - A commanded valve protective action stays sealed in until feedback confirms position.
// - A breaker trip stays sealed in until feedback confirms the breaker is open.
// - Valve protection is fail-safe: produced by de-energizing the output.
// - Breaker coil and shunt relay stay energized normally, de-energize to trip.
// - Breaker trips are produced only by de-energizing the module output.
`timescale 1ns/100ps
`default_nettype none

module valve_breaker_actuation_priority #(
  parameter int NUM_VALVES = valve_actuation_pkg::DEFAULT_VALVES // Components below this index are valves
) (
  input wire logic CLK, // System clock, 40 MHz
  input wire logic RESETN, // Synchronous reset, active low
  input wire valve_actuation_pkg::division_in_t [1:0] DIV_IN, // Per-division demands, commands, feedback
  output var logic [1:0][NUM_VALVES-1:0] SOLENOID_ENERGIZE, // Valve solenoid drive per division
  output var logic [1:0][valve_actuation_pkg::NS_INPUTS-NUM_VALVES-1:0] UNDERVOLTAGE_COIL_ENERGIZE, // Breaker coil
  output var logic [1:0][valve_actuation_pkg::NS_INPUTS-NUM_VALVES-1:0] SHUNT_RELAY_ENERGIZE, // Shunt-trip relay
  output var valve_actuation_pkg::comp_vec_t [1:0] SEAL_ACTIVE, // Seal-in held by any module
  output var valve_actuation_pkg::comp_vec_t [1:0] ACTION_COMPLETE, // One-cycle pulse when a seal releases
  output var logic [1:0] NS_REFUSED, // Enabled nonsafety request being overridden
  output var logic [1:0] MODULE_DISAGREE, // Both modules in service but drives differ
  output var logic [1:0] DIVISION_DARK // No module in service in the division
);

  localparam int NC = valve_actuation_pkg::NS_INPUTS;
  localparam int NB = NC - NUM_VALVES;
  localparam int ND = valve_actuation_pkg::NUM_DIVISIONS;
  localparam int NM = valve_actuation_pkg::NUM_MODULES;

  // Two-stage synchronisers for the hardwired field and switch inputs
  valve_actuation_pkg::division_in_t [ND-1:0] meta_r;
  valve_actuation_pkg::division_in_t [ND-1:0] sync_r;

  // Per-module results and per-division combined views
  valve_actuation_pkg::module_out_t [ND-1:0][NM-1:0] mod_out;
  valve_actuation_pkg::comp_vec_t [ND-1:0] drive_any;
  valve_actuation_pkg::comp_vec_t [ND-1:0] seal_any;
  valve_actuation_pkg::comp_vec_t [ND-1:0] seal_prev_r;
  logic [ND-1:0] blocked_any;
  logic [ND-1:0] disagree_nxt;
  logic [ND-1:0] dark_nxt;

  // Output registers
  logic [ND-1:0][NUM_VALVES-1:0] solenoid_r;
  logic [ND-1:0][NB-1:0] uv_coil_r;
  logic [ND-1:0][NB-1:0] shunt_relay_r;
  valve_actuation_pkg::comp_vec_t [ND-1:0] seal_r;
  valve_actuation_pkg::comp_vec_t [ND-1:0] complete_r;
  logic [ND-1:0] refused_r;
  logic [ND-1:0] disagree_r;
  logic [ND-1:0] dark_r;

  // A division whose modules share a drive register would tie the two together
  function automatic logic pair_differs(
    input valve_actuation_pkg::comp_vec_t a,
    input valve_actuation_pkg::comp_vec_t b
  );
    return |(a ^ b);
  endfunction : pair_differs

  // First synchroniser stage: read only by the second stage
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      meta_r <= {ND{valve_actuation_pkg::DIV_IN_RESET}};
    end else begin
      meta_r <= DIV_IN;
    end
  end

  // Second synchroniser stage: the only view the logic takes of the pins
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      sync_r <= {ND{valve_actuation_pkg::DIV_IN_RESET}};
    end else begin
      sync_r <= meta_r;
    end
  end

  genvar d, m;
  generate
    for (d = 0; d < ND; d++) begin : g_div
      // Each division runs its own redundant pair with no cross-division wiring
      for (m = 0; m < NM; m++) begin : g_mod
        priority_arbitration_logic u_module (
          .clk(CLK),
          .resetn(RESETN),
          .in_service(sync_r[d].module_in_service[m]),
          .safety_demand(sync_r[d].safety_demand),
          .ns_command(sync_r[d].ns_command),
          .ns_enable(sync_r[d].ns_enable),
          .position_reached(sync_r[d].position_reached),
          .result(mod_out[d][m])
        );
      end

      // Either module alone keeps the load energized
      assign drive_any[d] = mod_out[d][0].energize | mod_out[d][1].energize;
      assign seal_any[d] = mod_out[d][0].sealed | mod_out[d][1].sealed;
      assign blocked_any[d] = |(mod_out[d][0].ns_blocked | mod_out[d][1].ns_blocked);

      // Disagreement only counts when both modules are actually in service
      assign disagree_nxt[d] = (&sync_r[d].module_in_service)
        & pair_differs(mod_out[d][0].energize, mod_out[d][1].energize);
      assign dark_nxt[d] = ~(|sync_r[d].module_in_service);

      // Valve solenoids: high opens the valve, low closes it
      always_ff @(posedge CLK) begin
        if (!RESETN) begin
          solenoid_r[d] <= {NUM_VALVES{valve_actuation_pkg::ENERGIZE_RESET}};
        end else begin
          solenoid_r[d] <= drive_any[d][NUM_VALVES-1:0];
        end
      end

      // Breaker coil and shunt relay share the module drive; both drop to trip
      always_ff @(posedge CLK) begin
        if (!RESETN) begin
          uv_coil_r[d] <= {NB{valve_actuation_pkg::ENERGIZE_RESET}};
          shunt_relay_r[d] <= {NB{valve_actuation_pkg::ENERGIZE_RESET}};
        end else begin
          uv_coil_r[d] <= drive_any[d][NC-1:NUM_VALVES];
          shunt_relay_r[d] <= drive_any[d][NC-1:NUM_VALVES];
        end
      end

      // Seal status and the release pulse that marks a completed action
      always_ff @(posedge CLK) begin
        if (!RESETN) begin
          seal_r[d] <= valve_actuation_pkg::VEC_RESET;
          seal_prev_r[d] <= valve_actuation_pkg::VEC_RESET;
          complete_r[d] <= valve_actuation_pkg::VEC_RESET;
        end else begin
          seal_r[d] <= seal_any[d];
          seal_prev_r[d] <= seal_any[d];
          complete_r[d] <= seal_prev_r[d] & ~seal_any[d];
        end
      end

      // Division health and nonsafety refusal indications
      always_ff @(posedge CLK) begin
        if (!RESETN) begin
          refused_r[d] <= 1'b0;
          disagree_r[d] <= 1'b0;
          dark_r[d] <= 1'b0;
        end else begin
          refused_r[d] <= blocked_any[d];
          disagree_r[d] <= disagree_nxt[d];
          dark_r[d] <= dark_nxt[d];
        end
      end
    end
  endgenerate

  // Every top-level output is a flip-flop
  assign SOLENOID_ENERGIZE = solenoid_r;
  assign UNDERVOLTAGE_COIL_ENERGIZE = uv_coil_r;
  assign SHUNT_RELAY_ENERGIZE = shunt_relay_r;
  assign SEAL_ACTIVE = seal_r;
  assign ACTION_COMPLETE = complete_r;
  assign NS_REFUSED = refused_r;
  assign MODULE_DISAGREE = disagree_r;
  assign DIVISION_DARK = dark_r;

endmodule : valve_breaker_actuation_priority

`default_nettype wire

// [tb/valve_priority_chk.sv]
// Checker for the actuation priority block, bound to its top module
`timescale 1ns/100ps
`default_nettype none

module valve_priority_chk #(
  parameter int NUM_VALVES = 10 // Components below this index are valves
) (
  input wire logic CLK, // Clock
  input wire logic RESETN, // Reset, active low
  input wire valve_actuation_pkg::division_in_t [1:0] DIV_IN, // Division inputs
  input wire logic [1:0][NUM_VALVES-1:0] SOLENOID_ENERGIZE, // Valve drive
  input wire logic [1:0][valve_actuation_pkg::NS_INPUTS-NUM_VALVES-1:0] UNDERVOLTAGE_COIL_ENERGIZE, // Coil
  input wire logic [1:0][valve_actuation_pkg::NS_INPUTS-NUM_VALVES-1:0] SHUNT_RELAY_ENERGIZE, // Relay
  input wire valve_actuation_pkg::comp_vec_t [1:0] SEAL_ACTIVE, // Seal state
  input wire valve_actuation_pkg::comp_vec_t [1:0] ACTION_COMPLETE, // Release pulse
  input wire logic [1:0] NS_REFUSED, // Refusal flag
  input wire logic [1:0] MODULE_DISAGREE, // Drive mismatch
  input wire logic [1:0] DIVISION_DARK // No module fitted
);
  logic [2:0] up_r;
  valve_actuation_pkg::division_in_t [1:0] h_r [6];
  // Input history and cycles since reset, so the fixed latency is judged on steady inputs only
  always_ff @(posedge CLK) begin
    if (!RESETN) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
    h_r[0] <= DIV_IN;
    for (int i = 1; i < 6; i++) h_r[i] <= h_r[i-1];
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  for (genvar d = 0; d < 2; d++) begin : g_div
    valve_actuation_pkg::comp_vec_t dem, prn, drv;
    logic en_off, dark;
    // Conditions held through the last three decision points
    assign dem = h_r[3][d].safety_demand & h_r[4][d].safety_demand & h_r[5][d].safety_demand;
    assign prn = ~(h_r[3][d].position_reached | h_r[4][d].position_reached | h_r[5][d].position_reached);
    assign en_off = !(h_r[3][d].ns_enable | h_r[4][d].ns_enable | h_r[5][d].ns_enable);
    // The dark flag skips the module stage, so it answers one sample earlier
    assign dark = (h_r[2][d].module_in_service | h_r[3][d].module_in_service | h_r[4][d].module_in_service
      | h_r[5][d].module_in_service) == 2'h0;
    assign drv = {UNDERVOLTAGE_COIL_ENERGIZE[d], SOLENOID_ENERGIZE[d]};
    demand_trip_a: assert property (up_r == 3'h7 |-> (drv & dem) == '0)
      else $error("drive energized under protective demand");
    shunt_follow_a: assert property (SHUNT_RELAY_ENERGIZE[d] == UNDERVOLTAGE_COIL_ENERGIZE[d])
      else $error("shunt relay differs from coil");
    seal_set_a: assert property (up_r == 3'h7 && h_r[3][d].module_in_service != 2'h0
      |-> (dem & ~SEAL_ACTIVE[d]) == '0)
      else $error("demand without seal");
    seal_hold_a: assert property (up_r == 3'h7 && h_r[3][d].module_in_service == h_r[5][d].module_in_service
      |-> ($past(SEAL_ACTIVE[d]) & ~SEAL_ACTIVE[d] & prn) == '0)
      else $error("seal released without feedback");
    sealed_dark_a: assert property ((drv & SEAL_ACTIVE[d]) == '0)
      else $error("sealed component energized");
    // The pulse rises on the same edge that the seal output falls
    complete_pulse_a: assert property (up_r == 3'h7 |->
      ACTION_COMPLETE[d] == ($past(SEAL_ACTIVE[d]) & ~SEAL_ACTIVE[d]))
      else $error("completion pulse wrong");
    enable_gate_a: assert property (up_r == 3'h7 && en_off |-> (drv & ~$past(drv)) == '0)
      else $error("drive rose with enable off");
    dark_flag_a: assert property (up_r == 3'h7 && dark |-> DIVISION_DARK[d] && drv == '0)
      else $error("dark division not flagged or driven");
    disagree_flag_a: assert property (up_r == 3'h7 && MODULE_DISAGREE[d]
      |-> h_r[2][d].module_in_service == 2'h3)
      else $error("disagreement flagged without both modules");
  end
  release_c: cover property (up_r == 3'h7 && ACTION_COMPLETE[0] != '0);
  disagree_c: cover property (MODULE_DISAGREE[0]);
  refuse_c: cover property (NS_REFUSED[1]);
  dark_c: cover property (DIVISION_DARK[1]);
endmodule : valve_priority_chk

bind valve_breaker_actuation_priority valve_priority_chk #(.NUM_VALVES(NUM_VALVES)) u_chk (.CLK(CLK),
  .RESETN(RESETN), .DIV_IN(DIV_IN), .SOLENOID_ENERGIZE(SOLENOID_ENERGIZE),
  .UNDERVOLTAGE_COIL_ENERGIZE(UNDERVOLTAGE_COIL_ENERGIZE), .SHUNT_RELAY_ENERGIZE(SHUNT_RELAY_ENERGIZE),
  .SEAL_ACTIVE(SEAL_ACTIVE), .ACTION_COMPLETE(ACTION_COMPLETE), .NS_REFUSED(NS_REFUSED),
  .MODULE_DISAGREE(MODULE_DISAGREE), .DIVISION_DARK(DIVISION_DARK));

`default_nettype wire

// [tb/valve_plant_model.sv]
// Plant model: valves and breakers reach the protective position after a travel time
`timescale 1ns/100ps
`default_nettype none

module valve_plant_model (
  input wire logic clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic slow, // Long travel time
  input wire valve_actuation_pkg::comp_vec_t [1:0] drive, // Division drives
  output var valve_actuation_pkg::comp_vec_t reached // Protective position contacts
);
  logic [4:0] trav_r [14];
  // A component moves once either division drops its drive
  always_ff @(posedge clk) begin
    for (int i = 0; i < 14; i++) begin
      if (!resetn || (drive[0][i] && drive[1][i])) trav_r[i] <= 5'h00;
      else if (trav_r[i] != 5'h1F) trav_r[i] <= trav_r[i] + 5'h01;
      reached[i] <= resetn && trav_r[i] >= (slow ? 5'h14 : 5'h03);
    end
  end
endmodule : valve_plant_model

`default_nettype wire

// [tb/tb_valve_breaker_actuation_priority.sv]
// Testbench for the two-division actuation priority block
`timescale 1ns/100ps
`default_nettype none

module tb_valve_breaker_actuation_priority;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic slow = 1'b0;
  valve_actuation_pkg::division_in_t [1:0] div_in = '0;
  logic [1:0][13:0] dem_v = '0;
  logic [1:0][13:0] nsc_v = '0;
  logic [1:0] en_v = '0;
  logic [1:0][1:0] mis_v = '0;
  logic [1:0][9:0] sol;
  logic [1:0][3:0] uv;
  logic [1:0][3:0] shunt;
  logic [1:0][13:0] drv;
  valve_actuation_pkg::comp_vec_t [1:0] seal;
  valve_actuation_pkg::comp_vec_t [1:0] done;
  valve_actuation_pkg::comp_vec_t reached;
  logic [1:0] refused;
  logic [1:0] dark;
  logic [1:0] disagree;
  int fail_count = 0;
  int checked = 0;
  int seed = 16443;
  int d;
  int i;
  int n;
  assign drv = {uv[1], sol[1], uv[0], sol[0]};
  valve_breaker_actuation_priority #(.NUM_VALVES(10)) u_dut (.CLK(clk), .RESETN(resetn), .DIV_IN(div_in),
    .SOLENOID_ENERGIZE(sol), .UNDERVOLTAGE_COIL_ENERGIZE(uv), .SHUNT_RELAY_ENERGIZE(shunt), .SEAL_ACTIVE(seal),
    .ACTION_COMPLETE(done), .NS_REFUSED(refused), .MODULE_DISAGREE(disagree), .DIVISION_DARK(dark));
  valve_plant_model u_plant (.clk(clk), .resetn(resetn), .slow(slow), .drive(drv), .reached(reached));
  // Clock at 40 MHz
  initial forever #12.5 clk = ~clk;
  // Inputs reach the block on the falling edge
  always @(negedge clk) begin
    for (int k = 0; k < 2; k++) div_in[k] <= '{safety_demand: dem_v[k], ns_command: nsc_v[k],
      ns_enable: en_v[k], position_reached: reached, module_in_service: mis_v[k]};
  end
  task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Expected drive of a division with one component tripped
  function automatic logic [13:0] trip_exp(input int idx);
    return 14'h3FFF & ~(14'h0001 << idx);
  endfunction : trip_exp
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : cyc
  task report_and_stop;
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    cyc(2);
    check("reset drive", 14'h0000, drv[0] | drv[1]);
    @(negedge clk) resetn = 1'b1;
    mis_v = 4'hF;
    en_v = 2'h3;
    nsc_v = '1;
    cyc(9);
    check("drive up 0", 14'h3FFF, drv[0]);
    check("drive up 1", 14'h3FFF, drv[1]);
    check("shunt", 14'h00FF, {6'h00, shunt});
    for (int k = 0; k < 10; k++) begin
      d = $unsigned($random(seed)) % 2;
      i = (k < 2) ? k * 13 : $unsigned($random(seed)) % 14;
      slow = $random(seed);
      mis_v[d] = 2'h1;
      cyc(6);
      mis_v[d] = 2'h3;
      cyc(3);
      check("disagree on return", 14'h0001 << d, {12'h000, disagree});
      cyc(3);
      mis_v[d] = ($unsigned($random(seed)) % 3) + 1;
      cyc(6);
      check("one module left", 14'h3FFF, drv[d]);
      check("modules agree", 14'h0000, {12'h000, disagree});
      dem_v[d][i] = 1'b1;
      cyc(8);
      check("tripped", trip_exp(i), drv[d]);
      check("other division", 14'h3FFF, drv[1-d]);
      check("sealed", 14'h0001 << i, seal[d]);
      check("refused", 14'h0001, {13'h0000, refused[d]});
      dem_v[d][i] = 1'b0;
      // Fast travel releases within a few cycles, so only the slow case waits first
      if (slow) begin
        cyc(6);
        check("seal held", 14'h0001 << i, seal[d] | drv[d][i]);
      end
      n = 0;
      while (seal[d][i] !== 1'b0 && n < 60) begin
        cyc(1);
        n++;
      end
      if (n == 60) begin
        fail_count++;
        $display("CHECK FAILED seal release expected 0 seen 1");
        report_and_stop;
      end
      check("complete", 14'h0001 << i, done[d]);
      cyc(1);
      check("reenergized", 14'h3FFF, drv[d]);
    end
    en_v[0] = 1'b0;
    nsc_v[0] = '0;
    cyc(8);
    check("enable off holds", 14'h3FFF, drv[0]);
    en_v[0] = 1'b1;
    cyc(8);
    check("one switch all", 14'h0000, drv[0]);
    nsc_v[0] = $random(seed);
    cyc(8);
    check("pattern", nsc_v[0], drv[0]);
    mis_v[1] = 2'h0;
    cyc(8);
    check("dark", 14'h0002, {12'h000, dark});
    check("dark drive", 14'h0000, drv[1]);
    report_and_stop;
  end
endmodule : tb_valve_breaker_actuation_priority

`default_nettype wire
